// ### design/wdit_pkg.sv
`default_nettype none
package wdit_pkg;
    // byte offsets on the 32-bit bus, one word per register
    localparam int              WDIT_ADR_W       = 8;
    localparam logic [7:0]      WDIT_ADR_CSR1    = 8'h00;
    localparam logic [7:0]      WDIT_ADR_CSR2    = 8'h04;
    localparam logic [7:0]      WDIT_ADR_COUNT   = 8'h08;
    localparam logic [7:0]      WDIT_ADR_HALT2   = 8'h0C;
    localparam logic [7:0]      WDIT_ADR_IRQ_ST  = 8'h10;
    localparam logic [7:0]      WDIT_ADR_IRQ_MSK = 8'h14;

    // wd_ctrl_status_one fields
    localparam int              CSR1_RUN         = 0;
    localparam int              CSR1_RUN_GATE    = 1;
    localparam int              CSR1_MODE        = 2;
    localparam int              CSR1_MODE_GATE   = 3;
    localparam int              CSR1_RSTF        = 4;
    // wd_ctrl_status_two fields
    localparam int              CSR2_OVF         = 0;
    localparam int              CSR2_SRC         = 1;
    localparam int              CSR2_SRC_GATE    = 2;
    // clock_halt_reg_two field
    localparam int              HALT2_WDCK       = 0;
    // interrupt status / mask fields
    localparam int              IRQ_OVF          = 0;
    localparam int              IRQ_RST          = 1;
    localparam int              IRQ_W            = 2;

    // reset values and counter limits
    localparam logic [7:0]      COUNT_RST        = 8'h00;
    localparam logic [7:0]      COUNT_MAX        = 8'hFF;
    localparam logic            HALT2_RST        = 1'b1;
    localparam logic [1:0]      IRQ_RST_VAL      = 2'h0;

    // default tick dividers, in input clocks per count step
    localparam int              SYS_DIV_DEF      = 64;
    localparam int              OSC_DIV_DEF      = 1;

    typedef enum logic {
        WDIT_MODE_WATCHDOG,
        WDIT_MODE_INTERVAL
    } wdit_mode_type;

    typedef enum logic {
        WDIT_SRC_SYSTEM,
        WDIT_SRC_OSC
    } wdit_src_type;

    typedef enum logic [1:0] {
        WDIT_WR_IDLE,
        WDIT_WR_PEND
    } wdit_wr_state_type;
endpackage
`default_nettype wire

// ### design/wdit_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module wdit_tick_gen
    import wdit_pkg::*;
#(
    parameter int SYS_DIV = SYS_DIV_DEF,
    parameter int OSC_DIV = OSC_DIV_DEF
)
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  osc_i,
    input  wire logic  src_osc_i,
    input  wire logic  en_i,
    output logic       tick_o
);
    localparam int DIV_W = 16;

    logic              osc_s1_q;
    logic              osc_s2_q;
    logic              osc_s3_q;
    logic [DIV_W-1:0]  div_q;
    logic              step;
    logic [DIV_W-1:0]  limit;

    // the oscillator comes from another clock domain
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end
        else
        begin
            osc_s1_q <= osc_i;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    assign step  = src_osc_i ? (osc_s2_q & ~osc_s3_q) : 1'b1;
    assign limit = src_osc_i ? DIV_W'(OSC_DIV - 1) : DIV_W'(SYS_DIV - 1);

    // divider is held clear in standby so no clock reaches the counter
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !en_i)
        begin
            div_q  <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= 1'b0;
            if (step)
            begin
                if (div_q >= limit)
                begin
                    div_q  <= '0;
                    tick_o <= 1'b1;
                end
                else
                begin
                    div_q <= div_q + DIV_W'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### design/wdit_top.sv
//
// Contract
// [R01] eight-bit up count, read/write, resets zero
// [R02] watchdog wrap: internal reset, cause flag set
// [R03] interval mode wrap raises interval interrupt
// [R04] interrupt request follows overflow flag
// [R05] overflow flag cleared only by zero write
// [R06] software stops timer before switching modes
// [R07] clock-stop bit honoured only while stopped
// [R08] clock-stop cleared while running: keeps counting
// [R09] run cleared, stop already zero: standby
// [R10] halt bit zero stops clock, one restores
// [R11] oscillator-clocked count write visible within step
// [R12] no overflow between write and read-back
// [R13] gate bit written with guarded bit, reads one
// [R14] guarded bits change only when gate allows
// [R15] count advances only while run bit set
// [R16] mode select; interval overflow never resets
`timescale 1ns/1ps
`default_nettype none
module wdit_top
    import wdit_pkg::*;
#(
    parameter int SYS_DIV = SYS_DIV_DEF,
    parameter int OSC_DIV = OSC_DIV_DEF
)
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [WDIT_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  osc_i,
    output logic                       int_o,
    output logic                       itv_irq_o,
    output logic                       wd_reset_o,
    output logic                       standby_o
);
    logic                 ack_q;
    logic [31:0]          dat_q;
    logic                 req;
    logic                 wr;
    logic [7:0]           wbyte;

    logic                 run_q;
    wdit_mode_type        mode_q;
    wdit_src_type         src_q;
    logic                 rstf_q;
    logic                 ovf_q;
    logic                 halt_q;
    logic [7:0]           count_q;
    logic [7:0]           pend_q;
    wdit_wr_state_type    wst_q;
    logic [IRQ_W-1:0]     irq_st_q;
    logic [IRQ_W-1:0]     irq_msk_q;
    logic                 rst_pulse_q;

    logic                 standby;
    logic                 tick;
    logic                 step_ev;
    logic                 wrap_ev;
    logic                 wd_ev;
    logic                 itv_ev;
    logic                 csr1_wr;
    logic                 csr2_wr;
    logic                 count_wr;

    function automatic logic hit(input logic [WDIT_ADR_W-1:0] adr,
                                 input logic [7:0]            off);
        hit = (adr == off);
    endfunction

    // a guarded field is written only when its gate bit is written as zero
    function automatic logic gated(input logic [7:0] d, input int gate);
        gated = ~d[gate];
    endfunction

    function automatic logic [31:0] rdmux(input logic [WDIT_ADR_W-1:0] adr);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (hit(adr, WDIT_ADR_CSR1))
        begin
            v[CSR1_RUN]       = run_q;
            v[CSR1_RUN_GATE]  = 1'b1; // [R13]
            v[CSR1_MODE]      = (mode_q == WDIT_MODE_INTERVAL);
            v[CSR1_MODE_GATE] = 1'b1; // [R13]
            v[CSR1_RSTF]      = rstf_q;
        end
        else if (hit(adr, WDIT_ADR_CSR2))
        begin
            v[CSR2_OVF]      = ovf_q;
            v[CSR2_SRC]      = (src_q == WDIT_SRC_OSC);
            v[CSR2_SRC_GATE] = 1'b1; // [R13]
        end
        else if (hit(adr, WDIT_ADR_COUNT))
        begin
            v[7:0] = count_q; // [R01]
        end
        else if (hit(adr, WDIT_ADR_HALT2))
        begin
            v[HALT2_WDCK] = halt_q;
        end
        else if (hit(adr, WDIT_ADR_IRQ_ST))
        begin
            v[IRQ_W-1:0] = irq_st_q;
        end
        else if (hit(adr, WDIT_ADR_IRQ_MSK))
        begin
            v[IRQ_W-1:0] = irq_msk_q;
        end
        rdmux = v;
    endfunction

    // bus slave: ack one cycle after the request, dropped the next cycle;
    // unmapped offsets read zero and ignore writes but are still acked
    assign req      = wb_cyc_i & wb_stb_i;
    assign wr       = req & ack_q & wb_we_i & wb_sel_i[0];
    assign wbyte    = wb_dat_i[7:0];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    assign csr1_wr  = wr & hit(wb_adr_i, WDIT_ADR_CSR1);
    assign csr2_wr  = wr & hit(wb_adr_i, WDIT_ADR_CSR2);
    assign count_wr = wr & hit(wb_adr_i, WDIT_ADR_COUNT) & ~standby;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_q <= 32'h0000_0000;
        end
        else if (req && !ack_q && !wb_we_i)
        begin
            dat_q <= rdmux(wb_adr_i);
        end
    end

    // standby is decided from the current bits, so clearing run with the
    // halt bit already low stops the clock in that same write
    assign standby   = ~halt_q & ~run_q; // [R07] [R08] [R09] [R10]
    assign standby_o = standby;

    wdit_tick_gen #(
        .SYS_DIV (SYS_DIV),
        .OSC_DIV (OSC_DIV)
    ) u_tick (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .osc_i     (osc_i),
        .src_osc_i (src_q == WDIT_SRC_OSC),
        .en_i      (~standby), // [R10]
        .tick_o    (tick)
    );

    // a pending oscillator-side write consumes its step without counting
    assign step_ev = tick & ~standby & run_q & (wst_q == WDIT_WR_IDLE) & ~count_wr; // [R15] [R12]
    assign wrap_ev = step_ev & (count_q == COUNT_MAX);
    assign wd_ev   = wrap_ev & (mode_q == WDIT_MODE_WATCHDOG); // [R02]
    assign itv_ev  = wrap_ev & (mode_q == WDIT_MODE_INTERVAL); // [R03] [R16]

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_q <= 1'b0;
        end
        else if (csr1_wr && gated(wbyte, CSR1_RUN_GATE))
        begin
            run_q <= wbyte[CSR1_RUN]; // [R14]
        end
    end

    // mode changes are not blocked while running; switching mid-count
    // can disturb the count, and software is expected to stop first
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= WDIT_MODE_WATCHDOG;
        end
        else if (csr1_wr && gated(wbyte, CSR1_MODE_GATE))
        begin
            mode_q <= wbyte[CSR1_MODE] ? WDIT_MODE_INTERVAL : WDIT_MODE_WATCHDOG; // [R14] [R16]
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            src_q <= WDIT_SRC_SYSTEM;
        end
        else if (csr2_wr && gated(wbyte, CSR2_SRC_GATE))
        begin
            src_q <= wbyte[CSR2_SRC] ? WDIT_SRC_OSC : WDIT_SRC_SYSTEM; // [R14]
        end
    end

    // reset cause: set by a watchdog wrap, cleared by writing zero; set wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rstf_q <= 1'b0;
        end
        else if (wd_ev)
        begin
            rstf_q <= 1'b1; // [R02]
        end
        else if (csr1_wr && !wbyte[CSR1_RSTF])
        begin
            rstf_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ovf_q <= 1'b0;
        end
        else if (itv_ev)
        begin
            ovf_q <= 1'b1; // [R03]
        end
        else if (csr2_wr && !wbyte[CSR2_OVF])
        begin
            ovf_q <= 1'b0; // [R05]
        end
    end

    assign itv_irq_o = ovf_q; // [R04]

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            halt_q <= HALT2_RST;
        end
        else if (wr && hit(wb_adr_i, WDIT_ADR_HALT2))
        begin
            halt_q <= wbyte[HALT2_WDCK]; // [R10]
        end
    end

    // internal reset request, one clock wide
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rst_pulse_q <= 1'b0;
        end
        else
        begin
            rst_pulse_q <= wd_ev; // [R02]
        end
    end

    assign wd_reset_o = rst_pulse_q;

    // with the oscillator selected a write is parked until the next
    // count step, so read-back lags by at most one step
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wst_q  <= WDIT_WR_IDLE;
            pend_q <= COUNT_RST;
        end
        else
        begin
            case (wst_q)
                WDIT_WR_IDLE:
                begin
                    if (count_wr && src_q == WDIT_SRC_OSC)
                    begin
                        pend_q <= wbyte;
                        wst_q  <= WDIT_WR_PEND; // [R11]
                    end
                end
                WDIT_WR_PEND:
                begin
                    if (count_wr)
                    begin
                        pend_q <= wbyte;
                    end
                    else if (tick || src_q == WDIT_SRC_SYSTEM)
                    begin
                        wst_q <= WDIT_WR_IDLE;
                    end
                end
                default:
                begin
                    wst_q <= WDIT_WR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_q <= COUNT_RST; // [R01]
        end
        else if (count_wr && src_q == WDIT_SRC_SYSTEM)
        begin
            count_q <= wbyte; // [R01]
        end
        else if (wst_q == WDIT_WR_PEND && !count_wr && (tick || src_q == WDIT_SRC_SYSTEM))
        begin
            count_q <= pend_q; // [R11] [R12]
        end
        else if (step_ev)
        begin
            count_q <= count_q + 8'h01; // [R15]
        end
    end

    // sticky event bits: write one clears, a new event wins over the clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_st_q <= IRQ_RST_VAL;
        end
        else
        begin
            for (int i = 0; i < IRQ_W; i++)
            begin
                if (wr && hit(wb_adr_i, WDIT_ADR_IRQ_ST) && wbyte[i])
                begin
                    irq_st_q[i] <= 1'b0;
                end
            end
            if (itv_ev)
            begin
                irq_st_q[IRQ_OVF] <= 1'b1;
            end
            if (wd_ev)
            begin
                irq_st_q[IRQ_RST] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_msk_q <= IRQ_RST_VAL;
        end
        else if (wr && hit(wb_adr_i, WDIT_ADR_IRQ_MSK))
        begin
            irq_msk_q <= wbyte[IRQ_W-1:0];
        end
    end

    assign int_o = |(irq_st_q & irq_msk_q);
endmodule
`default_nettype wire

// ### bench/wdit_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module wdit_top_chk
    import wdit_pkg::*;
#(
    parameter int SYS_DIV = SYS_DIV_DEF,
    parameter int OSC_DIV = OSC_DIV_DEF
)
(
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [WDIT_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]            wb_sel_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  osc_i,
    input wire logic                  int_o,
    input wire logic                  itv_irq_o,
    input wire logic                  wd_reset_o,
    input wire logic                  standby_o
);
    logic wr_ok;

    assign wr_ok = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_wdrst_pulse: assert property (wd_reset_o |=> !wd_reset_o)
        else $error("reset pulse too long");
    chk_ovf_clear: assert property ($fell(itv_irq_o)
        |-> $past(wr_ok && wb_adr_i == WDIT_ADR_CSR2 && !wb_dat_i[CSR2_OVF]))
        else $error("overflow flag fell without zero write");
    chk_ovf_no_reset: assert property ($rose(itv_irq_o) |-> !wd_reset_o ##1 !wd_reset_o)
        else $error("interval overflow gave reset");
    chk_stby_cause: assert property ($rose(standby_o)
        |-> $past(wr_ok && (wb_adr_i == WDIT_ADR_CSR1 || wb_adr_i == WDIT_ADR_HALT2)))
        else $error("standby without control write");
    chk_wrap_running: assert property (wd_reset_o |-> !$past(standby_o))
        else $error("wrap while in standby");
    chk_stopped_quiet: assert property (standby_o ##1 standby_o
        |-> !wd_reset_o && !$rose(itv_irq_o))
        else $error("overflow while stopped");

    cover property (wd_reset_o);
    cover property ($rose(itv_irq_o));
    cover property ($rose(standby_o));
endmodule

bind wdit_top wdit_top_chk #(.SYS_DIV(SYS_DIV), .OSC_DIV(OSC_DIV)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_i(osc_i), .int_o(int_o),
    .itv_irq_o(itv_irq_o), .wd_reset_o(wd_reset_o), .standby_o(standby_o)
);
`default_nettype wire

// ### bench/wdit_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module wdit_top_test
    import wdit_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic        osc   = 1'b0;
    logic [2:0]  osc_div = 3'h0;
    logic [7:0]  adr   = 8'h00;
    logic [3:0]  sel   = 4'h0;
    logic [31:0] dat   = 32'h0;
    logic [31:0] rdat;
    wire logic [31:0] dat_o;
    wire logic        ack;
    wire logic        int_w;
    wire logic        itv;
    wire logic        wdr;
    wire logic        stby;
    int          n_errors   = 0;
    int          num_checks = 0;
    int          n_cyc      = 0;

    always #25 clk_i = ~clk_i;
    // oscillator stand-in: one rising edge every 14 clocks, slow enough for the synchroniser
    always @(posedge clk_i)
    begin
        if (osc_div == 3'h6)
        begin
            osc_div <= 3'h0;
            osc     <= ~osc;
        end
        else
        begin
            osc_div <= osc_div + 3'h1;
        end
    end

    wdit_top #(.SYS_DIV(2), .OSC_DIV(1)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .osc_i(osc), .int_o(int_w), .itv_irq_o(itv), .wd_reset_o(wdr), .standby_o(stby)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    task automatic t_reset;
        rc(WDIT_ADR_COUNT, 32'h0);
        rc(WDIT_ADR_CSR1, 32'h0A);
        rc(WDIT_ADR_CSR2, 32'h04);
        rc(WDIT_ADR_HALT2, 32'h01);
        rc(WDIT_ADR_IRQ_ST, 32'h0);
        rc(8'h20, 32'h0);
        chk_bit(stby, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_count;
        wr(WDIT_ADR_COUNT, 32'h5A);
        rc(WDIT_ADR_COUNT, 32'h5A);
        wr(WDIT_ADR_CSR1, 32'h03);
        repeat (8) @(posedge clk_i);
        rc(WDIT_ADR_CSR1, 32'h0A);
        rc(WDIT_ADR_COUNT, 32'h5A);
        $display("test count done");
    endtask

    task automatic t_watchdog;
        wr(WDIT_ADR_IRQ_MSK, 32'h02);
        wr(WDIT_ADR_COUNT, 32'hFE);
        wr(WDIT_ADR_CSR1, 32'h01);
        repeat (40) if (wdr !== 1'b1) @(posedge clk_i);
        chk_bit(wdr, 1'b1);
        @(posedge clk_i);
        chk_bit(int_w, 1'b1);
        rc(WDIT_ADR_CSR1, 32'h1B);
        rc(WDIT_ADR_IRQ_ST, 32'h02);
        wr(WDIT_ADR_CSR1, 32'h00);
        rc(WDIT_ADR_CSR1, 32'h0A);
        wr(WDIT_ADR_IRQ_MSK, 32'h00);
        @(posedge clk_i);
        chk_bit(int_w, 1'b0);
        wr(WDIT_ADR_IRQ_ST, 32'h02);
        rc(WDIT_ADR_IRQ_ST, 32'h00);
        $display("test watchdog done");
    endtask

    task automatic t_interval;
        wr(WDIT_ADR_CSR1, 32'h04);
        wr(WDIT_ADR_COUNT, 32'hFE);
        wr(WDIT_ADR_CSR1, 32'h05);
        repeat (40) if (itv !== 1'b1) @(posedge clk_i);
        chk_bit(itv, 1'b1);
        chk_bit(wdr, 1'b0);
        wr(WDIT_ADR_CSR1, 32'h04);
        rc(WDIT_ADR_IRQ_ST, 32'h01);
        wr(WDIT_ADR_CSR2, 32'h05);
        rc(WDIT_ADR_CSR2, 32'h05);
        chk_bit(itv, 1'b1);
        wr(WDIT_ADR_CSR2, 32'h04);
        @(posedge clk_i);
        chk_bit(itv, 1'b0);
        rc(WDIT_ADR_CSR1, 32'h0E);
        wr(WDIT_ADR_IRQ_ST, 32'h01);
        $display("test interval done");
    endtask

    task automatic t_standby;
        logic [31:0] c;
        wr(WDIT_ADR_CSR1, 32'h00);
        wr(WDIT_ADR_COUNT, 32'h10);
        wr(WDIT_ADR_CSR1, 32'h01);
        wr(WDIT_ADR_HALT2, 32'h00);
        @(posedge clk_i);
        chk_bit(stby, 1'b0);
        wb(1'b0, WDIT_ADR_COUNT, 32'h0);
        chk_bit(rdat[7:0] > 8'h10, 1'b1);
        wr(WDIT_ADR_CSR1, 32'h00);
        @(posedge clk_i);
        chk_bit(stby, 1'b1);
        wb(1'b0, WDIT_ADR_COUNT, 32'h0);
        c = rdat;
        wr(WDIT_ADR_COUNT, 32'h77);
        repeat (10) @(posedge clk_i);
        rc(WDIT_ADR_COUNT, c);
        wr(WDIT_ADR_HALT2, 32'h01);
        @(posedge clk_i);
        chk_bit(stby, 1'b0);
        $display("test standby done");
    endtask

    // oscillator source: a count write is parked until the next step
    task automatic t_osc;
        int k;
        wr(WDIT_ADR_CSR2, 32'h02);
        rc(WDIT_ADR_CSR2, 32'h06);
        wr(WDIT_ADR_COUNT, 32'h33);
        repeat (16) @(posedge clk_i);
        rc(WDIT_ADR_COUNT, 32'h33);
        wr(WDIT_ADR_CSR1, 32'h04);
        wr(WDIT_ADR_CSR1, 32'h05);
        wr(WDIT_ADR_COUNT, 32'hFF);
        k = 0;
        do
        begin
            chk_bit(itv, 1'b0);
            wb(1'b0, WDIT_ADR_COUNT, 32'h0);
            k++;
        end
        while (rdat[7:0] !== 8'hFF && k < 12);
        chk(rdat, 32'hFF);
        repeat (40) if (itv !== 1'b1) @(posedge clk_i);
        chk_bit(itv, 1'b1);
        wr(WDIT_ADR_CSR1, 32'h04);
        wr(WDIT_ADR_CSR2, 32'h04);
        wr(WDIT_ADR_IRQ_ST, 32'h01);
        $display("test oscillator done");
    endtask

    always @(posedge clk_i)
    begin
        n_cyc++;
        if (n_cyc == 5000)
        begin
            n_errors++;
            stop_test;
        end
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_count;
        t_watchdog;
        t_interval;
        t_standby;
        t_osc;
        stop_test;
    end
endmodule
`default_nettype wire
